// ### hw/hius_pkg.sv
// package: register map, field layout and codes of the microframe scheduler
package hius_pkg;
   localparam int          ADDR_W          = 12;
   localparam int          NUM_UFRAMES     = 8;
   localparam int          RESULT_W        = 3;
   localparam int          FRAME_W         = 5;
   localparam int          BYTE_CNT_W      = 12;
   // register byte offsets
   localparam logic [11:0] OFS_WORD4       = 12'h000;
   localparam logic [11:0] OFS_FRAME       = 12'h004;
   localparam logic [11:0] OFS_CTRL        = 12'h008;
   localparam logic [11:0] OFS_IRQ_STAT    = 12'h00C;
   localparam logic [11:0] OFS_IRQ_MASK    = 12'h010;
   localparam logic [11:0] OFS_BUS_FRAME   = 12'h014;
   localparam logic [11:0] OFS_BYTES_BASE  = 12'h020;
   // word4 layout
   localparam int          MASK_LSB        = 0;
   localparam int          RESULT_LSB      = 8;
   // result code bits
   localparam int          RES_XACT_ERR    = 0;
   localparam int          RES_BABBLE      = 1;
   localparam int          RES_UNDERRUN    = 2;
   // frame register: descriptor frame number field at bits 7..3
   localparam int          RATE_LSB        = 3;
   // ctrl register
   localparam int          CTRL_TOKEN_IN   = 0;
   // irq status bits
   localparam int          IRQ_DONE        = 0;
   localparam int          IRQ_ERROR       = 1;
   localparam int          IRQ_W           = 2;
   localparam logic [31:0] RESET_WORD      = 32'h0000_0000;
endpackage : hius_pkg

// ### hw/hius_sched.sv
// microframe slot scheduler with per-microframe result codes and byte counts
//
// Operation
// - eight three-bit result codes, microframe seven at top, zero at bits 10..8
// - result code written only after that microframe's transaction completed
// - result bit zero flags a transaction error, in and out
// - result bit one flags babble, in-token only
// - result bit two flags underrun, out-token only
// - software only sets slot bits; hardware clears each after processing
// - slot mask consulted only when descriptor frame equals bus frame
// - transaction issued in microframe i only when slot bit i set
// - sparse masks select only the microframes whose bits are set
// - received byte count stored per microframe when slot and frame match, in-token only
//
// Our own choices: the address map and the APB slave port.
`timescale 1ns/10ps
module hius_sched #(
   parameter int NUM_UFRAMES = hius_pkg::NUM_UFRAMES
) (
   input  wire logic                                pclk,
   input  wire logic                                presetn,
   input  wire logic                                psel,
   input  wire logic                                penable,
   input  wire logic                                pwrite,
   input  wire logic [hius_pkg::ADDR_W-1:0]         paddr,
   input  wire logic [31:0]                         pwdata,
   output logic      [31:0]                         prdata,
   output logic                                     pready,
   output logic                                     pslverr,
   input  wire logic [hius_pkg::FRAME_W-1:0]        bus_frame,
   input  wire logic [2:0]                          bus_uframe,
   input  wire logic                                uframe_start,
   output logic                                     xact_req,
   output logic      [2:0]                          xact_uframe,
   output logic                                     xact_token_in,
   input  wire logic                                xact_done,
   input  wire logic                                xact_err,
   input  wire logic                                xact_babble,
   input  wire logic                                xact_underrun,
   input  wire logic [hius_pkg::BYTE_CNT_W-1:0]     xact_bytes,
   output logic                                     irq
);
   // word4 packing holds exactly eight slots
   if (NUM_UFRAMES != 8)
   begin : g_bad
      $error("hius_sched serves exactly eight microframes");
   end

   // word4 and the read word are packed by hand around these widths
   if (hius_pkg::RESULT_W != 3 || hius_pkg::FRAME_W != 5 || hius_pkg::BYTE_CNT_W != 12 || hius_pkg::IRQ_W != 2)
   begin : g_bad_pkg
      $error("hius_sched needs the package field widths it was packed for");
   end

   localparam int BW = hius_pkg::BYTE_CNT_W;

   typedef enum logic [0:0] {HIUS_IDLE, HIUS_BUSY} hius_state_e;

   hius_state_e                        state_q;
   logic [NUM_UFRAMES-1:0]             slot_mask_q;
   logic [3*NUM_UFRAMES-1:0]           result_q;
   logic [7:0]                         frame_field_q;
   logic                               token_in_q;
   logic [hius_pkg::IRQ_W-1:0]         irq_stat_q;
   logic [hius_pkg::IRQ_W-1:0]         irq_mask_q;
   logic [BW*NUM_UFRAMES-1:0]          bytes_q;
   logic [2:0]                         cur_uf_q;
   logic                               xact_req_q;
   logic [31:0]                        prdata_q;
   logic [31:0]                        prdata_d;

   // bus inputs are from the transaction engine on pclk, no synchroniser needed
   logic                               wr_en;
   logic                               rd_en;
   logic                               rd_setup;
   logic                               busy;
   logic                               frame_match;
   logic                               launch;
   logic [2:0]                         code_d;
   logic [hius_pkg::IRQ_W-1:0]         irq_set;

   // per-microframe strobes and register selects
   logic [NUM_UFRAMES-1:0]             uf_done;
   logic [NUM_UFRAMES-1:0]             mask_set;
   logic [NUM_UFRAMES-1:0]             sel_bytes;
   logic                               sel_word4;
   logic                               sel_frame;
   logic                               sel_ctrl;
   logic                               sel_stat;
   logic                               sel_mask;
   logic                               sel_bus;

   assign wr_en    = psel & penable & pwrite;
   assign rd_en    = psel & penable & ~pwrite;
   assign rd_setup = psel & ~penable & ~pwrite;
   assign pready   = 1'b1;
   assign pslverr  = 1'b0;
   // shared by launch, strobes and the status word
   assign busy     = (state_q == HIUS_BUSY);

   // address decode, one select per register; unmapped addresses select nothing
   assign sel_word4 = (paddr == hius_pkg::OFS_WORD4);
   assign sel_frame = (paddr == hius_pkg::OFS_FRAME);
   assign sel_ctrl  = (paddr == hius_pkg::OFS_CTRL);
   assign sel_stat  = (paddr == hius_pkg::OFS_IRQ_STAT);
   assign sel_mask  = (paddr == hius_pkg::OFS_IRQ_MASK);
   assign sel_bus   = (paddr == hius_pkg::OFS_BUS_FRAME);

   assign frame_match = (frame_field_q[7:hius_pkg::RATE_LSB] == bus_frame);

   // issue only on armed slot
   // a start that meets a slow answer is dropped; its slot waits for the next matching frame
   assign launch = uframe_start & frame_match & slot_mask_q[bus_uframe] & ~busy;

   always_comb
   begin
      code_d = 3'h0;
      code_d[hius_pkg::RES_XACT_ERR] = xact_err;
      code_d[hius_pkg::RES_BABBLE]   = xact_babble & token_in_q;
      code_d[hius_pkg::RES_UNDERRUN] = xact_underrun & ~token_in_q;
   end

   // any result bit raises the error event, so one mask bit covers all three faults
   assign irq_set[hius_pkg::IRQ_DONE]  = busy & xact_done;
   assign irq_set[hius_pkg::IRQ_ERROR] = busy & xact_done & (|code_d);

   // one transaction in flight; the engine answers at its own pace
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q    <= HIUS_IDLE;
         cur_uf_q   <= 3'h0;
         xact_req_q <= 1'b0;
      end
      else
      begin
         case (state_q)
            HIUS_IDLE:
            begin
               if (launch)
               begin
                  state_q    <= HIUS_BUSY;
                  cur_uf_q   <= bus_uframe;
                  xact_req_q <= 1'b1;
               end
            end
            HIUS_BUSY:
            begin
               xact_req_q <= 1'b0;
               if (xact_done)
               begin
                  state_q <= HIUS_IDLE;
               end
            end
            default:
            begin
               state_q    <= HIUS_IDLE;
               xact_req_q <= 1'b0;
            end
         endcase
      end
   end

   assign xact_req      = xact_req_q;
   assign xact_uframe   = cur_uf_q;
   assign xact_token_in = token_in_q;

   // slot mask: software sets, hardware clears; a clear never hides a fresh set of another bit
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         slot_mask_q <= '0;
      end
      else
      begin
         for (int i = 0; i < NUM_UFRAMES; i++)
         begin
            if (mask_set[i])
            begin
               slot_mask_q[i] <= 1'b1;
            end
            else if (uf_done[i])
            begin
               slot_mask_q[i] <= 1'b0;
            end
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM_UFRAMES; g++)
      begin : g_uf
         // one strobe per microframe: result, byte count and slot clear share it
         assign uf_done[g] = busy & xact_done & (cur_uf_q == 3'(g));

         // only a one written to a slot bit arms it; zeros leave it alone
         assign mask_set[g] = wr_en & sel_word4 & pwdata[hius_pkg::MASK_LSB+g];

         // byte counts sit one word apart from their base
         assign sel_bytes[g] = (paddr == hius_pkg::OFS_BYTES_BASE + 12'(4*g));

         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               result_q[3*g +: 3] <= 3'h0;
            end
            else if (uf_done[g])
            begin
               result_q[3*g +: 3] <= code_d;
            end
         end

         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               bytes_q[BW*g +: BW] <= '0;
            end
            else if (uf_done[g] && token_in_q)
            begin
               bytes_q[BW*g +: BW] <= xact_bytes;
            end
         end
      end
   endgenerate

   // software configuration
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         frame_field_q <= 8'h00;
         token_in_q    <= 1'b0;
         irq_mask_q    <= '0;
      end
      else if (wr_en)
      begin
         if (sel_frame)
         begin
            frame_field_q <= pwdata[7:0];
         end
         if (sel_ctrl)
         begin
            token_in_q <= pwdata[hius_pkg::CTRL_TOKEN_IN];
         end
         if (sel_mask)
         begin
            irq_mask_q <= pwdata[hius_pkg::IRQ_W-1:0];
         end
      end
   end

   // sticky events: set beats write-one-to-clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_stat_q <= '0;
      end
      else
      begin
         for (int i = 0; i < hius_pkg::IRQ_W; i++)
         begin
            if (irq_set[i])
            begin
               irq_stat_q[i] <= 1'b1;
            end
            else if (wr_en && sel_stat && pwdata[i])
            begin
               irq_stat_q[i] <= 1'b0;
            end
         end
      end
   end

   assign irq = |(irq_stat_q & irq_mask_q);

   // read word chosen combinationally, registered in setup so it is ready in the access phase
   always_comb
   begin
      prdata_d = 32'h0000_0000;
      if (sel_word4)
      begin
         prdata_d = {result_q, slot_mask_q};
      end
      else if (sel_frame)
      begin
         prdata_d = {24'h00_0000, frame_field_q};
      end
      else if (sel_ctrl)
      begin
         prdata_d = {31'h0000_0000, token_in_q};
      end
      else if (sel_stat)
      begin
         prdata_d = {30'h0000_0000, irq_stat_q};
      end
      else if (sel_mask)
      begin
         prdata_d = {30'h0000_0000, irq_mask_q};
      end
      else if (sel_bus)
      begin
         prdata_d = {23'h00_0000, busy, bus_frame, bus_uframe};
      end
      else
      begin
         for (int i = 0; i < NUM_UFRAMES; i++)
         begin
            if (sel_bytes[i])
            begin
               prdata_d = {20'h0_0000, bytes_q[BW*i +: BW]};
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_q <= hius_pkg::RESET_WORD;
      end
      else if (rd_setup)
      begin
         prdata_q <= prdata_d;
      end
   end

   // gated to zero outside a read access so a stale word never sits on the bus
   assign prdata = rd_en ? prdata_q : 32'h0000_0000;

endmodule : hius_sched

// ### tb/hius_sched_properties.sv
// checker: port properties of the microframe scheduler
`timescale 1ns/10ps
module hius_sched_properties #(
   parameter int NUM_UFRAMES = 8
) (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [2:0]  bus_uframe,
   input wire logic        uframe_start,
   input wire logic        xact_req,
   input wire logic [2:0]  xact_uframe,
   input wire logic        xact_done,
   input wire logic        irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic pend_q;
   // pending from request to answer, for the single-outstanding check
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pend_q <= 1'b0;
      else if (xact_req)
         pend_q <= 1'b1;
      else if (xact_done)
         pend_q <= 1'b0;
   end
   sequence s_launch;
      uframe_start ##1 xact_req;
   endsequence
   a_req_after_start: assert property (xact_req |-> $past(uframe_start))
      else $error("request without start");
   a_req_slot: assert property (s_launch |-> xact_uframe == $past(bus_uframe))
      else $error("wrong microframe");
   a_one_outstanding: assert property (pend_q && !xact_done |-> !xact_req)
      else $error("request while busy");
   a_slot_held: assert property (xact_req |=> $stable(xact_uframe))
      else $error("pending slot changed");
   a_irq_cause: assert property ($rose(irq) |-> $past(xact_done) || ($past(psel) && $past(penable) && $past(pwrite)))
      else $error("irq without cause");
   a_irq_sticky: assert property (irq && !xact_done && !(psel && penable && pwrite) |=> irq)
      else $error("irq dropped");
   a_read_idle: assert property (!(psel && penable && !pwrite) |-> prdata == 32'h0)
      else $error("read data outside access");
   a_zero_wait: assert property (psel && penable |-> pready && !pslverr)
      else $error("access not completed");
endmodule : hius_sched_properties
bind hius_sched hius_sched_properties #(.NUM_UFRAMES(NUM_UFRAMES)) u_props (.*);

// ### tb/hius_engine_model.sv
// partner: transaction engine answering promptly or slowly
`timescale 1ns/10ps
module hius_engine_model (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        xact_req,
   input  wire logic [2:0]  xact_uframe,
   input  wire logic        inj_err,
   output logic             xact_done,
   output logic             xact_err,
   output logic             xact_babble,
   output logic             xact_underrun,
   output logic [11:0]      xact_bytes
);
   logic [3:0] cnt_q;
   logic [2:0] uf_q;
   // odd microframes answer slowly to stretch the busy window
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         {cnt_q, uf_q} <= '0;
      else if (xact_req)
         {cnt_q, uf_q} <= {xact_uframe[0] ? 4'h6 : 4'h1, xact_uframe};
      else if (cnt_q != 4'h0)
         cnt_q <= cnt_q - 4'h1;
   assign xact_done = cnt_q == 4'h1;
   // outcome flags valid only beside done
   assign {xact_err, xact_babble, xact_underrun} = {3{xact_done ~^ inj_err}};
   // byte count, inverted junk while idle
   assign xact_bytes = xact_done ? {9'h000, uf_q} + 12'h040 : ~({9'h000, uf_q} + 12'h040);
endmodule : hius_engine_model

// ### tb/tb.sv
// testbench: register and microframe scenarios
`timescale 1ns/10ps
module tb;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, uframe_start, inj_err;
   logic        xact_req, xact_token_in, xact_done, xact_err, xact_babble, xact_underrun, irq;
   logic [11:0] paddr, xact_bytes;
   logic [31:0] pwdata, prdata, rdat;
   logic [4:0]  bus_frame;
   logic [2:0]  bus_uframe, xact_uframe;
   logic [7:0]  issued;
   int          n_mismatch = 0;
   int          n_checks = 0;
   hius_sched u_hius_sched (.*);
   hius_engine_model u_hius_engine_model (.*);
   initial
   begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   always @(posedge pclk)
      if (xact_req === 1'b1)
         issued[xact_uframe] = 1'b1;
   task summarize;
      if (n_mismatch == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : summarize
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdat = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : xfer
   task rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(nm, rdat, exp);
   endtask : rd
   // a microframe lasts 16 cycles here, long enough for the slow answer
   task run(input logic [7:0] m, input logic [4:0] f, input logic [7:0] exp);
      xfer(1'b1, hius_pkg::OFS_WORD4, {24'h0, m});
      bus_frame <= f;
      issued = 8'h0;
      for (int u = 0; u < 8; u++)
      begin
         bus_uframe <= 3'(u);
         uframe_start <= 1'b1;
         @(posedge pclk);
         uframe_start <= 1'b0;
         repeat (15) @(posedge pclk);
      end
      chk("issued", {24'h0, issued}, {24'h0, exp});
   endtask : run
   initial
   begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata, bus_frame, bus_uframe, uframe_start, inj_err} = '0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd("word4", hius_pkg::OFS_WORD4, 32'h0);
      rd("unmapped", 12'hFFC, 32'h0);
      chk("irq", {31'h0, irq}, 32'h0);
      xfer(1'b1, hius_pkg::OFS_FRAME, 32'h28);
      xfer(1'b1, hius_pkg::OFS_CTRL, 32'h1);
      chk("token", {31'h0, xact_token_in}, 32'h1);
      rd("ctrl", hius_pkg::OFS_CTRL, 32'h1);
      rd("frame", hius_pkg::OFS_FRAME, 32'h28);
      xfer(1'b1, hius_pkg::OFS_IRQ_MASK, 32'h3);
      run(8'h55, 5'h05, 8'h55);
      rd("word4", hius_pkg::OFS_WORD4, 32'h0);
      rd("bytes2", hius_pkg::OFS_BYTES_BASE + 12'h008, 32'h42);
      rd("bytes1", hius_pkg::OFS_BYTES_BASE + 12'h004, 32'h0);
      rd("stat", hius_pkg::OFS_IRQ_STAT, 32'h1);
      chk("irq", {31'h0, irq}, 32'h1);
      xfer(1'b1, hius_pkg::OFS_IRQ_STAT, 32'h1);
      chk("irq", {31'h0, irq}, 32'h0);
      run(8'h88, 5'h05, 8'h88);
      run(8'hFF, 5'h06, 8'h00);
      rd("word4", hius_pkg::OFS_WORD4, 32'hFF);
      run(8'h00, 5'h05, 8'hFF);
      rd("word4", hius_pkg::OFS_WORD4, 32'h0);
      xfer(1'b1, hius_pkg::OFS_IRQ_MASK, 32'h0);
      xfer(1'b1, hius_pkg::OFS_IRQ_STAT, 32'h3);
      inj_err <= 1'b1;
      run(8'h01, 5'h05, 8'h01);
      xfer(1'b1, hius_pkg::OFS_CTRL, 32'h0);
      chk("token", {31'h0, xact_token_in}, 32'h0);
      run(8'h80, 5'h05, 8'h80);
      rd("word4", hius_pkg::OFS_WORD4, 32'hA0000300);
      chk("irq", {31'h0, irq}, 32'h0);
      rd("stat", hius_pkg::OFS_IRQ_STAT, 32'h3);
      xfer(1'b1, hius_pkg::OFS_IRQ_MASK, 32'h2);
      chk("irq", {31'h0, irq}, 32'h1);
      rd("busstat", hius_pkg::OFS_BUS_FRAME, 32'h2F);
      // mid-run reset returns every register to zero
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("irq", {31'h0, irq}, 32'h0);
      rd("word4", hius_pkg::OFS_WORD4, 32'h0);
      rd("stat", hius_pkg::OFS_IRQ_STAT, 32'h0);
      summarize();
   end
   initial
   begin
      repeat (20000) @(posedge pclk);
      n_mismatch++;
      summarize();
   end
endmodule : tb
